// [common/asrc_params.svh]
`ifndef ASRC_PARAMS_SVH
`define ASRC_PARAMS_SVH
`define ASRC_CLK_PERIOD_NS   10
`define ASRC_ADDR_W          17
`define ASRC_DATA_W          8
`define ASRC_T_CYCLE_NS      70
`define ASRC_T_ACCESS_NS     70
`define ASRC_T_SELWE_NS      55
`define ASRC_T_ADDRWE_NS     55
`define ASRC_T_WDATA_NS      35
`define ASRC_T_RECOV_NS      5
`define ASRC_T_HZ_NS         25
`define ASRC_T_CDR_NS        0
`define ASRC_CNT_W           4
`define ASRC_CNT_ZERO        4'h0
`define ASRC_CNT_ONE         4'h1
`define ASRC_SYNC_CYC        2
`endif

// [common/asrc_pkg.sv]
package asrc_pkg;
  typedef struct packed {
    logic        write;
    logic [16:0] addr;
    logic [7:0]  wdata;
  } asrc_req_s;
  typedef struct packed {
    logic       primarySelectN;
    logic       secondarySelect;
    logic       writeStrobeN;
    logic       outputGateN;
  } asrc_ctl_s;
  typedef enum logic [2:0] {ST_IDLE, ST_RSETUP, ST_READ, ST_RFLOAT, ST_WSETUP, ST_WRITE,
                            ST_WRECOV, ST_RETAIN} asrc_state_e;
endpackage : asrc_pkg

// [rtl/asrc_delay_cnt.sv]
`timescale 1ns/1ns
`include "asrc_params.svh"
// loadable down-counter; done while count is zero
module asrc_delay_cnt #(
  parameter int W = `ASRC_CNT_W
) (
  input  wire logic         mclk,   // clock
  input  wire logic         rst_n,  // sync reset
  input  wire logic         load,   // load strobe
  input  wire logic [W-1:0] value,  // cycles to wait
  output logic              done    // count expired
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  assign cnt_next = load ? value : (done ? cnt_reg : cnt_reg - W'(1));
  assign done = (cnt_reg == W'(0));
  always_ff @(posedge mclk) begin
    if (!rst_n) cnt_reg <= W'(0);
    else cnt_reg <= cnt_next;
  end
endmodule : asrc_delay_cnt

// [rtl/asrc_sram_host.sv]
`timescale 1ns/1ns
`include "asrc_params.svh"
// Overview of operation
// - write only while primary select low, strobe low, secondary high.
// - address changes only while the strobe and selects are inactive.
// - never drive data while the memory drives the lines.
// - strobe held high through every read.
// - selected with strobe high is a read; gate high floats lines.
// - chip selected at least 55 ns before write end.
// - address stable at least 55 ns before write end.
// - write data valid at least 35 ns before write end.
// - deselect no later than retention supply drop.
// - primary-select retention holds secondary select at a rail.
// - secondary-select retention may let other pins float.
module asrc_sram_host
  import asrc_pkg::*;
#(
  parameter int ADDR_W = `ASRC_ADDR_W,
  parameter int DATA_W = `ASRC_DATA_W
) (
  input  wire logic              mclk,              // 100 MHz clock
  input  wire logic              rst_n,             // sync reset, low
  input  wire asrc_pkg::asrc_req_s reqData,         // request fields
  input  wire logic              reqValid,          // request strobe
  output logic                   reqReady,          // idle, takes request
  output logic [DATA_W-1:0]      rdData,            // read word
  output logic                   rdValid,           // read done pulse
  output logic                   wrDone,            // write done pulse
  input  wire logic              retainReq,         // enter retention
  output logic                   retainAck,         // deselected for retention
  output logic [ADDR_W-1:0]      wordAddressLines,  // address pins
  output asrc_pkg::asrc_ctl_s    ctlPins,           // control pins
  input  wire logic [DATA_W-1:0] sharedDataIn,      // data pins in
  output logic [DATA_W-1:0]      sharedDataOut,     // data pins out
  output logic                   sharedDataOe       // high while driving
);
  import asrc_pkg::*;

  localparam int CW = `ASRC_CNT_W;
  // least times round up to whole cycles
  localparam int P = `ASRC_CLK_PERIOD_NS;
  localparam logic [CW-1:0] ACC_CYC = CW'((`ASRC_T_ACCESS_NS + P - 1) / P);
  localparam logic [CW-1:0] SEL_CYC = CW'((`ASRC_T_SELWE_NS + P - 1) / P);
  localparam logic [CW-1:0] DAT_CYC = CW'((`ASRC_T_WDATA_NS + P - 1) / P);
  localparam logic [CW-1:0] HZ_CYC  = CW'((`ASRC_T_HZ_NS + P - 1) / P);
  localparam logic [CW-1:0] REC_CYC = CW'((`ASRC_T_RECOV_NS + P - 1) / P);
  localparam int WR_PULSE = (`ASRC_T_SELWE_NS > `ASRC_T_ADDRWE_NS) ?
                            `ASRC_T_SELWE_NS : `ASRC_T_ADDRWE_NS;
  localparam logic [CW-1:0] WR_CYC  = CW'((WR_PULSE + P - 1) / P);
  localparam int CYC_NS = `ASRC_T_CYCLE_NS;
  // takes kept at least one full memory cycle apart
  localparam logic [CW-1:0] GAP_CYC = CW'((CYC_NS + P - 1) / P);
  localparam logic [CW-1:0] SYN_CYC = CW'(`ASRC_SYNC_CYC);

  asrc_state_e state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdat_reg;
  logic [DATA_W-1:0] rd_reg;
  logic              oe_reg;
  logic              rdv_reg;
  logic              wrd_reg;
  logic              ack_reg;
  // ready from a flop, so no path from state decode straight to the port
  logic              ready_reg;
  logic              gapDone;
  asrc_ctl_s         ctl_reg, ctl_next;
  logic              cntLoad, cntDone;
  logic [CW-1:0]     cntVal;

  asrc_delay_cnt #(.W(CW)) u_cnt (
    .mclk  (mclk),
    .rst_n (rst_n),
    .load  (cntLoad),
    .value (cntVal),
    .done  (cntDone)
  );

  // second counter guards the cycle time, independent of the phase counter
  asrc_delay_cnt #(.W(CW)) u_gap (
    .mclk  (mclk),
    .rst_n (rst_n),
    .load  (takeReq),
    .value (GAP_CYC),
    .done  (gapDone)
  );

  // two-flop sampling of the data pins; bits are not coherent, hence the margin
  logic [DATA_W-1:0] dinMeta_reg, dinSync_reg;
  for (genvar b = 0; b < DATA_W; b++) begin : g_sync
    always_ff @(posedge mclk) begin
      dinMeta_reg[b] <= sharedDataIn[b];
      dinSync_reg[b] <= dinMeta_reg[b];
    end
  end

  wire takeReq  = ready_reg && reqValid && !retainReq;
  // phase ends, shared by the pulse and capture flops
  wire rdFinish = (state_reg == ST_READ) && cntDone;
  wire wrFinish = (state_reg == ST_WRITE) && cntDone;
  wire goRead  = takeReq && !reqData.write;
  wire goWrite = takeReq && reqData.write;

  always_comb begin
    state_next = state_reg;
    cntLoad    = 1'b0;
    cntVal     = `ASRC_CNT_ZERO;
    unique case (state_reg)
      ST_IDLE: begin
        if (retainReq) state_next = ST_RETAIN;
        else if (goRead) begin
          state_next = ST_RSETUP;
        end else if (goWrite) begin
          state_next = ST_WSETUP;
        end
      end
      ST_RSETUP: begin
        state_next = ST_READ;
        cntLoad = 1'b1;
        // sync delay of two flops added to access time
        cntVal = ACC_CYC + SYN_CYC;
      end
      ST_READ: if (cntDone) begin
        state_next = ST_RFLOAT;
        cntLoad = 1'b1;
        cntVal = HZ_CYC;
      end
      ST_RFLOAT: if (cntDone && gapDone) begin
        state_next = ST_IDLE;
      end
      ST_WSETUP: begin
        state_next = ST_WRITE;
        cntLoad = 1'b1;
        cntVal = (WR_CYC > DAT_CYC) ? WR_CYC : DAT_CYC;
      end
      ST_WRITE: if (cntDone) begin
        state_next = ST_WRECOV;
        cntLoad = 1'b1;
        cntVal = REC_CYC;
      end
      ST_WRECOV: if (cntDone && gapDone) begin
        state_next = ST_IDLE;
      end
      // address and control pins stay driven, data pins released; letting them float would gain nothing here
      ST_RETAIN: if (!retainReq) begin
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // pin levels per state; address moves only in idle when all controls inactive
  always_comb begin
    ctl_next = '{primarySelectN: 1'b1, secondarySelect: 1'b1,
                 writeStrobeN: 1'b1, outputGateN: 1'b1};
    unique case (state_next)
      ST_RSETUP, ST_READ: begin
        ctl_next.primarySelectN = 1'b0;
        ctl_next.outputGateN    = 1'b0;
      end
      ST_WSETUP: ctl_next.writeStrobeN = 1'b0;
      ST_WRITE: begin
        ctl_next.writeStrobeN   = 1'b0;
        ctl_next.primarySelectN = 1'b0;
      end
      ST_RETAIN: ctl_next.secondarySelect = 1'b0;
      default: ;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      ctl_reg   <= '{1'b1, 1'b1, 1'b1, 1'b1};
      addr_reg  <= '0;
      wdat_reg  <= '0;
      rd_reg    <= '0;
      oe_reg    <= 1'b0;
      rdv_reg   <= 1'b0;
      wrd_reg   <= 1'b0;
      ack_reg   <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      ctl_reg   <= ctl_next;
      if (takeReq) begin
        addr_reg <= reqData.addr;
        wdat_reg <= reqData.wdata;
      end
      // drive only while strobe is low, so memory output is floating
      oe_reg  <= (state_next == ST_WRITE);
      if (rdFinish) rd_reg <= dinSync_reg;
      rdv_reg <= rdFinish;
      wrd_reg <= wrFinish;
      ack_reg <= (state_next == ST_RETAIN);
      ready_reg <= (state_next == ST_IDLE);
    end
  end

  assign reqReady         = ready_reg;
  assign wordAddressLines = addr_reg;
  assign ctlPins          = ctl_reg;
  assign sharedDataOut    = wdat_reg;
  assign sharedDataOe     = oe_reg;
  assign rdData           = rd_reg;
  assign rdValid          = rdv_reg;
  assign wrDone           = wrd_reg;
  assign retainAck        = ack_reg;
endmodule : asrc_sram_host

// [tb/asrc_checker.sv]
`timescale 1ns/1ns
module asrc_checker
  import asrc_pkg::*;
#(parameter int ADDR_W = 17, parameter int DATA_W = 8) (
  input wire logic mclk, // clock
  input wire logic rst_n, // reset
  input wire asrc_pkg::asrc_req_s reqData, // request
  input wire logic reqValid, // strobe
  input wire logic reqReady, // idle
  input wire logic retainReq, // retention in
  input wire logic rdValid, // read done
  input wire logic wrDone, // write done
  input wire logic retainAck, // retained
  input wire logic [ADDR_W-1:0] wordAddressLines, // address
  input wire asrc_pkg::asrc_ctl_s ctlPins, // controls
  input wire logic [DATA_W-1:0] sharedDataOut, // data out
  input wire logic sharedDataOe // data enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire take = reqValid && reqReady && !retainReq;
  wire wrOn = !ctlPins.primarySelectN && ctlPins.secondarySelect && !ctlPins.writeStrobeN;
  a_addr_idle: assert property (!$stable(wordAddressLines) |-> !wrOn && !$past(wrOn))
    else $error("address moved during write");
  a_no_clash: assert property (sharedDataOe |-> !ctlPins.writeStrobeN && ctlPins.outputGateN)
    else $error("data driven while memory may drive");
  a_read_strobe: assert property (!ctlPins.outputGateN |-> ctlPins.writeStrobeN)
    else $error("strobe low while gate open");
  a_sel_setup: assert property ($rose(ctlPins.writeStrobeN) |-> $past(wrOn, 6))
    else $error("select too short before write end");
  a_addr_setup: assert property ($rose(ctlPins.writeStrobeN) |->
    $past(wordAddressLines, 6) == $past(wordAddressLines)) else $error("address unstable");
  a_data_setup: assert property ($rose(ctlPins.writeStrobeN) |-> $past(sharedDataOe, 4) &&
    $past(sharedDataOut, 4) == $past(sharedDataOut)) else $error("write data too late");
  a_write_real: assert property (wrDone |-> $past(wrOn))
    else $error("write done without write overlap");
  a_retain_low: assert property (retainAck |-> !ctlPins.secondarySelect && !sharedDataOe)
    else $error("retention not deselected");
  a_read_time: assert property (take && !reqData.write |-> ##[10:12] rdValid)
    else $error("read answer late");
  a_write_time: assert property (take && reqData.write |-> ##9 wrDone)
    else $error("write answer late");
endmodule : asrc_checker
bind asrc_sram_host asrc_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (.mclk(mclk),
  .rst_n(rst_n), .reqData(reqData), .reqValid(reqValid), .reqReady(reqReady),
  .retainReq(retainReq), .rdValid(rdValid), .wrDone(wrDone), .retainAck(retainAck),
  .wordAddressLines(wordAddressLines), .ctlPins(ctlPins), .sharedDataOut(sharedDataOut),
  .sharedDataOe(sharedDataOe));

// [tb/asrc_sram_model.sv]
`timescale 1ns/1ns
module asrc_sram_model
  import asrc_pkg::*;
(
  input wire logic [16:0] addr, // word address
  input wire asrc_pkg::asrc_ctl_s ctl, // controls
  input wire logic [7:0] pins, // resolved data pins
  output logic [7:0] dout, // read word
  output logic drive // memory drives pins
);
  logic [7:0] mem [0:131071];
  logic selLate, gateLate, wrGone;
  logic [7:0] pinsLate;
  wire sel = !ctl.primarySelectN && ctl.secondarySelect;
  wire wr = sel && !ctl.writeStrobeN;
  assign #10 selLate = sel;
  assign #5 gateLate = !ctl.outputGateN;
  assign #5 wrGone = !wr;
  assign #1 pinsLate = pins;
  // release on deselect or strobe low is prompt, on gate high 5 ns late; strobe low or late select never drives
  assign drive = sel && selLate && gateLate && wrGone && ctl.writeStrobeN;
  always @(addr or sel) begin
    #10 dout = ~mem[addr];
    #60 dout = mem[addr];
  end
  // pins seen just before the write ends, so a same-edge release cannot leak in
  always @(negedge wr) mem[addr] = pinsLate;
endmodule : asrc_sram_model

// [tb/testbench.sv]
`timescale 1ns/1ns
module testbench;
  import asrc_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, retainReq = 1'b0;
  asrc_req_s reqData = '0;
  logic reqReady, rdValid, wrDone, retainAck, sharedDataOe, drive;
  logic [7:0] rdData, sharedDataOut, dout;
  logic [16:0] wordAddressLines;
  asrc_ctl_s ctlPins;
  // undriven pins show the inverse so a stale value never passes
  wire [7:0] pins = sharedDataOe ? sharedDataOut : drive ? dout : ~dout;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  always #5 mclk = ~mclk;
  asrc_sram_host dut_u (.mclk(mclk), .rst_n(rst_n), .reqData(reqData), .reqValid(reqValid),
    .reqReady(reqReady), .rdData(rdData), .rdValid(rdValid), .wrDone(wrDone),
    .retainReq(retainReq), .retainAck(retainAck), .wordAddressLines(wordAddressLines),
    .ctlPins(ctlPins), .sharedDataIn(pins), .sharedDataOut(sharedDataOut),
    .sharedDataOe(sharedDataOe));
  asrc_sram_model mem_u (.addr(wordAddressLines), .ctl(ctlPins), .pins(pins), .dout(dout),
    .drive(drive));
  task automatic print_verdict;
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [16:0] a, input logic [7:0] d);
    int n = 0;
    reqData = '{w, a, d};
    reqValid = 1'b1;
    while (reqReady !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    @(posedge mclk);
    #1 reqValid = 1'b0;
    check(reqReady === 1'b0, "ready while busy");
    n = 0;
    while ((w ? wrDone : rdValid) !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    check(n < 20 && (w || rdData === d), "transfer result");
  endtask : xfer
  task automatic t_rw;
    xfer(1'b1, 17'h00000, 8'ha5);
    xfer(1'b1, 17'h1ffff, 8'h3c);
    xfer(1'b0, 17'h00000, 8'ha5);
    xfer(1'b1, 17'h00000, 8'h5a);
    xfer(1'b0, 17'h1ffff, 8'h3c);
  endtask : t_rw
  task automatic t_retain;
    int n = 0;
    retainReq = 1'b1;
    reqData = '{1'b1, 17'h00000, 8'hff};
    reqValid = 1'b1;
    while (retainAck !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    check(n < 20 && !ctlPins.secondarySelect && !sharedDataOe, "retention entry");
    reqValid = 1'b0;
    retainReq = 1'b0;
    xfer(1'b0, 17'h00000, 8'h5a);
  endtask : t_retain
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    #1 rst_n = 1'b1;
    check(ctlPins === 4'hf && sharedDataOe === 1'b0, "reset pin levels");
    t_rw();
    t_retain();
    print_verdict();
  end
endmodule : testbench
